// >>> ascrp_defines.vh
// constants of the converter serial command and result port
// assumes inclusion by bare name from the port and its successive-approximation register
`ifndef ASCRP_DEFINES_VH
`define ASCRP_DEFINES_VH

// ----------------------------------------------------------------
// result format
// ----------------------------------------------------------------
`define ASCRP_RES_W 13
`define ASCRP_SIGN_IDX 4'hc
`define ASCRP_RES_RST 13'h0000

// ----------------------------------------------------------------
// serial clock counts, rising edges after the start bit
// ----------------------------------------------------------------
`define ASCRP_CNT_W 6
`define ASCRP_CNT_START 6'h00
`define ASCRP_CNT_MODE 6'h00
`define ASCRP_CNT_D2 6'h01
`define ASCRP_CNT_D1 6'h02
`define ASCRP_CNT_D0 6'h03
`define ASCRP_CNT_NULL 6'h05
`define ASCRP_CNT_SIGN 6'h06
`define ASCRP_CNT_LAST_MSB 6'h12
`define ASCRP_CNT_FIRST_LSB 6'h13
`define ASCRP_CNT_LAST_LSB 6'h1f
`define ASCRP_CNT_MAX 6'h20

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
`define ASCRP_ST_IDLE 2'h0
`define ASCRP_ST_HUNT 2'h1
`define ASCRP_ST_XFER 2'h2

`endif

// >>> ascrp_sar.v
// successive-approximation register, one result bit resolved per step
// assumes the comparator answers for the trial code before each step
`include "ascrp_defines.vh"
`default_nettype none

module ascrp_sar (
   // clock and reset
   input wire clk,
   input wire nrst,
   // control
   input wire clear,
   input wire step,
   input wire [3:0] bit_idx,
   input wire force_pos,
   // comparator: differential input at or above trial code
   input wire cmp_above,
   // results
   output reg [`ASCRP_RES_W-1:0] trial,
   output reg [`ASCRP_RES_W-1:0] result,
   output wire bit_out
);

   reg [`ASCRP_RES_W-1:0] next_result;

   // sign step compares against zero; single-ended never goes negative
   assign bit_out = (bit_idx == `ASCRP_SIGN_IDX) ? (~cmp_above & ~force_pos) : cmp_above;

   always @* begin
      next_result = result;
      next_result[bit_idx] = bit_out;
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trial <= `ASCRP_RES_RST;
         result <= `ASCRP_RES_RST;
      end else if (clear) begin
         trial <= `ASCRP_RES_RST;
         result <= `ASCRP_RES_RST;
      end else if (step) begin
         result <= next_result;
         // next trial keeps resolved bits and sets the one below
         if (bit_idx != 4'h0) begin
            trial <= next_result | (13'h0001 << (bit_idx - 4'h1));
         end else begin
            trial <= next_result;
         end
      end
   end

endmodule

`default_nettype wire

// >>> ascrp_port.v
// serial command and result port of a 13-bit differential converter
// assumes the master owns sclk, cs_n and din; all three are asynchronous
// to clk and are sampled here, so sclk must stay well below clk / 4
//
// What this block does
// - result is 13-bit two's complement, sign bit on top
// - sign 0 when positive input not lower
// - codes span +4095 down to -4096
// - listen only after chip select falls
// - chip select low at reset needs high first
// - first rising edge with din high starts
// - leading zeros before start are ignored
// - bit after start picks single or differential
// - three select bits follow, highest first
// - single-ended selects index; four-channel ignores bit2
// - differential picks pair, bit0 picks polarity
// - single-ended sign always sent as 0
// - sample from fourth rising to fifth falling
// - din ignored during sample completion clock
// - low null bit on following falling edge
// - sign then twelve bits most significant first
// - dout changes only on sclk falling edges, and clears to 0 when chip select goes high
// - repeat result least significant first afterwards
// - zeros after that while chip select low
// - power-down indication after conversion bits produced
// - works with sclk idling low or high
// - dout undriven before the null bit
`include "ascrp_defines.vh"
`default_nettype none

module ascrp_port (
   // clock and reset
   input wire clk,
   input wire nrst,
   // serial link pins
   input wire sclk,
   input wire cs_n,
   input wire din,
   output reg dout,
   output reg dout_oe_n,
   // configuration
   input wire four_chan_variant,
   // analog front end
   input wire cmp_above,
   output wire [`ASCRP_RES_W-1:0] dac_trial,
   output reg sample_en,
   output reg power_down,
   output reg [2:0] pos_chan,
   output reg [2:0] neg_chan,
   output reg neg_is_gnd,
   // status
   output reg input_mode_select,
   output reg chan_sel_bit2,
   output reg chan_sel_bit1,
   output reg chan_sel_bit0,
   output reg xfer_active,
   output wire [`ASCRP_RES_W-1:0] last_result
);

   // ----------------------------------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------------------------------
   reg sclk_m;
   reg sclk_s;
   reg sclk_d;
   reg cs_m;
   reg cs_s;
   reg cs_d;
   reg din_m;
   reg din_s;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_fall;

   // cs sync resets low so a chip select held low from power-up
   // never looks like a falling transition
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         cs_m <= 1'b0;
         cs_s <= 1'b0;
         cs_d <= 1'b0;
         din_m <= 1'b0;
         din_s <= 1'b0;
      end else begin
         sclk_m <= sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         cs_m <= cs_n;
         cs_s <= cs_m;
         cs_d <= cs_s;
         din_m <= din;
         din_s <= din_m;
      end
   end

   // both idle levels
   // a leading falling edge in idle-high mode finds no started frame
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   assign cs_fall = ~cs_s & cs_d;

   // ----------------------------------------------------------------
   // channel decode
   // ----------------------------------------------------------------
   // which channel drives one side of the comparator
   function [2:0] chan_of;
      input single;
      input four;
      input [2:0] sel;
      input neg_side;
      reg [2:0] s;
      begin
         s = sel;
         if (four) begin
            s[2] = 1'b0;
         end
         if (single) begin
            chan_of = s;
         end else begin
            chan_of = {s[2:1], s[0] ^ neg_side};
         end
      end
   endfunction

   wire [2:0] sel_now;
   assign sel_now = {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0};

   always @* begin
      pos_chan = chan_of(input_mode_select, four_chan_variant, sel_now, 1'b0);
      neg_chan = chan_of(input_mode_select, four_chan_variant, sel_now, 1'b1);
      neg_is_gnd = input_mode_select;
   end

   // ----------------------------------------------------------------
   // successive approximation
   // ----------------------------------------------------------------
   reg [1:0] state;
   reg [`ASCRP_CNT_W-1:0] cnt;
   wire in_msb;
   wire in_lsb;
   wire sar_step;
   wire sar_clear;
   wire sar_bit;
   wire [3:0] msb_idx;
   wire [3:0] lsb_idx;

   // bit position inside a phase; wraps outside it, so read only in that phase
   function [3:0] bit_pos;
      input [`ASCRP_CNT_W-1:0] hi;
      input [`ASCRP_CNT_W-1:0] lo;
      reg [`ASCRP_CNT_W-1:0] diff;
      begin
         diff = hi - lo;
         bit_pos = diff[3:0];
      end
   endfunction

   // count window test, both end points included
   function in_span;
      input [`ASCRP_CNT_W-1:0] c;
      input [`ASCRP_CNT_W-1:0] lo;
      input [`ASCRP_CNT_W-1:0] hi;
      begin
         in_span = (c >= lo) && (c <= hi);
      end
   endfunction

   assign in_msb = in_span(cnt, `ASCRP_CNT_SIGN, `ASCRP_CNT_LAST_MSB);
   assign in_lsb = in_span(cnt, `ASCRP_CNT_FIRST_LSB, `ASCRP_CNT_LAST_LSB);
   assign msb_idx = bit_pos(`ASCRP_CNT_LAST_MSB, cnt);
   assign lsb_idx = bit_pos(cnt, `ASCRP_CNT_FIRST_LSB);

   // one bit per clock
   // each falling edge of the msb-first phase resolves and sends one bit
   assign sar_step = (state == `ASCRP_ST_XFER) && sclk_fall && in_msb;
   assign sar_clear = (state == `ASCRP_ST_HUNT) && sclk_rise && din_s;

   ascrp_sar u_sar (
      .clk(clk),
      .nrst(nrst),
      .clear(sar_clear),
      .step(sar_step),
      .bit_idx(msb_idx),
      .force_pos(input_mode_select),
      .cmp_above(cmp_above),
      .trial(dac_trial),
      .result(last_result),
      .bit_out(sar_bit)
   );

   // ----------------------------------------------------------------
   // frame sequencing
   // ----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= `ASCRP_ST_IDLE;
         cnt <= `ASCRP_CNT_START;
         input_mode_select <= 1'b0;
         chan_sel_bit2 <= 1'b0;
         chan_sel_bit1 <= 1'b0;
         chan_sel_bit0 <= 1'b0;
         sample_en <= 1'b0;
         power_down <= 1'b1;
         dout <= 1'b0;
         dout_oe_n <= 1'b1;
         xfer_active <= 1'b0;
      end else if (cs_s) begin
         state <= `ASCRP_ST_IDLE;
         cnt <= `ASCRP_CNT_START;
         sample_en <= 1'b0;
         power_down <= 1'b1;
         dout <= 1'b0;
         dout_oe_n <= 1'b1;
         xfer_active <= 1'b0;
      end else begin
         case (state)
            `ASCRP_ST_IDLE: begin
               if (cs_fall) begin
                  state <= `ASCRP_ST_HUNT;
               end
            end
            `ASCRP_ST_HUNT: begin
               if (sclk_rise && din_s) begin
                  state <= `ASCRP_ST_XFER;
                  cnt <= `ASCRP_CNT_START;
                  power_down <= 1'b0;
                  xfer_active <= 1'b1;
               end
            end
            `ASCRP_ST_XFER: begin
               if (sclk_rise) begin
                  if (cnt != `ASCRP_CNT_MAX) begin
                     cnt <= cnt + 6'h01;
                  end
                  if (cnt == `ASCRP_CNT_MODE) begin
                     input_mode_select <= din_s;
                  end
                  if (cnt == `ASCRP_CNT_D2) begin
                     chan_sel_bit2 <= din_s;
                  end
                  if (cnt == `ASCRP_CNT_D1) begin
                     chan_sel_bit1 <= din_s;
                  end
                  if (cnt == `ASCRP_CNT_D0) begin
                     chan_sel_bit0 <= din_s;
                     sample_en <= 1'b1;
                  end
                  // din not read on the completion clock
               end
               if (sclk_fall) begin
                  if (cnt == `ASCRP_CNT_NULL) begin
                     sample_en <= 1'b0;
                     dout <= 1'b0;
                     dout_oe_n <= 1'b0;
                  end else if (in_msb) begin
                     dout <= sar_bit;
                  end else if (in_lsb) begin
                     dout <= last_result[lsb_idx];
                  end else if (cnt > `ASCRP_CNT_LAST_LSB) begin
                     dout <= 1'b0;
                  end
                  // converter powers down
                  // bias and comparator idle once the last bit is decided
                  if (cnt == `ASCRP_CNT_LAST_MSB) begin
                     power_down <= 1'b1;
                  end
               end
            end
            default: begin
               state <= `ASCRP_ST_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// >>> ascrp_port_monitor.sv
// checker for the converter serial port, bound onto its top module
// assumes the bench runs sclk at 8 clk a period
`include "ascrp_defines.vh"
`default_nettype none
module ascrp_port_monitor (
   // clock, reset and link
   input wire logic clk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic dout,
   input wire logic dout_oe_n,
   // front end and status
   input wire logic four_chan_variant,
   input wire logic [`ASCRP_RES_W-1:0] dac_trial,
   input wire logic sample_en,
   input wire logic power_down,
   input wire logic [2:0] pos_chan,
   input wire logic [2:0] neg_chan,
   input wire logic neg_is_gnd,
   input wire logic input_mode_select,
   input wire logic chan_sel_bit2,
   input wire logic chan_sel_bit1,
   input wire logic chan_sel_bit0,
   input wire logic xfer_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // ------------------------------
   // checks
   // ------------------------------
   sequence sample_s;
      sample_en [*8] ##[1:6] !sample_en;
   endsequence
   sequence null_s;
      !dout_oe_n && !dout;
   endsequence
   sample_hold_a: assert property ($rose(sample_en) |=> sample_s ##[0:5] null_s)
      else $error("sample window or null bit wrong");
   abort_release_a: assert property (cs_n [*6] |-> dout_oe_n && power_down && !xfer_active)
      else $error("frame not ended by chip select");
   idle_float_a: assert property ($rose(xfer_active) |-> dout_oe_n [*8])
      else $error("dout driven before null bit");
   fall_edge_a: assert property ($rose(sclk) |=> $stable(dout) [*3])
      else $error("dout moved after a rising edge");
   power_up_a: assert property ($fell(power_down) |-> dout_oe_n && !cs_n)
      else $error("power up outside frame head");
   trial_hold_a: assert property (power_down && !dout_oe_n |=> $stable(dac_trial))
      else $error("trial code moved while powered down");
   chan_map_a: assert property (pos_chan == {chan_sel_bit2 & !four_chan_variant,
      chan_sel_bit1, chan_sel_bit0})
      else $error("positive channel wrong");
   pair_a: assert property (neg_is_gnd == input_mode_select &&
      (input_mode_select || neg_chan == (pos_chan ^ 3'h1)))
      else $error("negative side wrong");
   // thirteen sclk periods of 8 clk separate the null bit from the last msb-first bit
   sequence conv_done_s;
      (!power_down || cs_n) ##[1:8] (power_down || dout_oe_n);
   endsequence
   power_after_a: assert property ($fell(dout_oe_n) |-> ##100 conv_done_s)
      else $error("power down not at end of conversion");
endmodule
bind ascrp_port ascrp_port_monitor mon (.clk, .nrst, .sclk, .cs_n, .dout, .dout_oe_n,
   .four_chan_variant, .dac_trial, .sample_en, .power_down, .pos_chan, .neg_chan,
   .neg_is_gnd, .input_mode_select, .chan_sel_bit2, .chan_sel_bit1, .chan_sel_bit0,
   .xfer_active);
`default_nettype wire

// >>> ascrp_host_model.sv
// host side of the serial link: frames one command and samples the reply
// assumes clk at 50 ns; sclk toggles only inside frames, 8 clk a period
`default_nettype none
module ascrp_host_model (
   // clock
   input wire logic clk,
   // link
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   logic got [0:63];
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      din = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask
   // ------------------------------
   // one frame
   // ------------------------------
   // framing
   task automatic frame(input logic idle, input logic [3:0] cmd, input int nz, input int nr);
      int k;
      sclk = idle;
      half();
      cs_n = 1'b0;
      half();
      for (int j = 0; j < nz + nr; j++) begin
         k = j - nz;
         sclk = 1'b0;
         // din held high after the command so a stray restart would show
         din = (k < 0) ? 1'b0 : (k == 0 || k > 4) ? 1'b1 : cmd[4 - k];
         half();
         sclk = 1'b1;
         if (k >= 0) got[k] = miso;
         half();
      end
      sclk = idle;
      half();
      cs_n = 1'b1;
      half();
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the converter serial port
// assumes the port, its bound checker and the host model compile first
`include "ascrp_defines.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, four_chan_variant, cmp_above, miso;
   logic miso_last = 1'b0;
   logic seen_act = 1'b0;
   wire sclk, cs_n, din, dout, dout_oe_n, power_down, xfer_active, neg_is_gnd;
   wire [`ASCRP_RES_W-1:0] dac_trial, last_result;
   wire [2:0] pos_chan, neg_chan;
   int chv [0:7];
   int vdiff;
   int fail_count = 0;
   int num_checks = 0;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ------------------------------
   // surroundings
   // ------------------------------
   // comparator stands in for the analog front end
   assign vdiff = chv[pos_chan] - (neg_is_gnd ? 0 : chv[neg_chan]);
   assign cmp_above = $signed(dac_trial) <= vdiff;
   // released line wanders so a stale bit is never read as valid
   assign miso = dout_oe_n ? ~miso_last : dout;
   always @(posedge clk) miso_last <= miso;
   always @(posedge clk) if (xfer_active === 1'b1) seen_act <= 1'b1;
   ascrp_port dut (
      .clk, .nrst, .sclk, .cs_n, .din, .dout, .dout_oe_n, .four_chan_variant,
      .cmp_above, .dac_trial, .sample_en(), .power_down, .pos_chan, .neg_chan,
      .neg_is_gnd, .input_mode_select(), .chan_sel_bit2(), .chan_sel_bit1(),
      .chan_sel_bit0(), .xfer_active, .last_result
   );
   ascrp_host_model host (.clk, .sclk, .cs_n, .din, .miso);
   task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // other channels hold a decoy so a wrong selection changes the code
   task automatic run(input logic [3:0] cmd, input logic fc, input logic idle,
                      input int nz, input int pv, input int nv);
      int p;
      int e;
      logic [12:0] ms;
      logic [12:0] ls;
      four_chan_variant = fc;
      for (int i = 0; i < 8; i++) chv[i] = 77;
      p = {fc ? 1'b0 : cmd[2], cmd[1:0]};
      chv[p] = pv;
      chv[p ^ 1] = nv;
      e = cmd[3] ? pv : pv - nv;
      e = (e > 4095) ? 4095 : e;
      e = (e < -4096) ? -4096 : (cmd[3] && e < 0) ? 0 : e;
      host.frame(idle, cmd, nz, 36);
      for (int i = 0; i < 13; i++) begin
         ms[12 - i] = host.got[7 + i];
         ls[i] = host.got[20 + i];
      end
      check("null bit", {12'h000, host.got[6]}, 13'h0000);
      check("msb first", ms, e[12:0]);
      check("lsb first", ls, e[12:0]);
      check("tail", {10'h000, host.got[33], host.got[34], host.got[35]}, 13'h0000);
      check("result register", last_result, e[12:0]);
      $display("test done, command %h", cmd);
   endtask
   // ------------------------------
   // stimulus
   // ------------------------------
   initial begin
      nrst = 1'b0;
      four_chan_variant = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      nrst = 1'b1;
      host.frame(1'b0, 4'h8, 0, 8);
      check("start with select low", {12'h000, seen_act}, 13'h0000);
      $display("test done, select low from reset");
      run(4'hd, 1'b0, 1'b0, 0, 4095, 0);
      run(4'h0, 1'b0, 1'b1, 3, 100, 100);
      run(4'h1, 1'b0, 1'b1, 6, 0, 4096);
      run(4'h6, 1'b0, 1'b0, 2, 10, 11);
      run(4'h7, 1'b1, 1'b0, 0, 6000, 0);
      run(4'hf, 1'b1, 1'b1, 1, 1234, 9);
      run(4'ha, 1'b0, 1'b0, 0, -50, 0);
      host.frame(1'b0, 4'h0, 0, 10);
      check("abort", {10'h000, dout_oe_n, power_down, xfer_active}, 13'h0006);
      $display("test done, abort");
      run(4'h5, 1'b0, 1'b0, 4, 300, 44);
      tally_and_finish();
   end
   initial begin
      #400000;
      fail_count++;
      $display("wrong value watchdog expected finish seen timeout");
      tally_and_finish();
   end
endmodule
`default_nettype wire
